// ===== logic/odac_defs.svh
// Constants of the octal DAC two-wire slave front end.
// Assumes inclusion by bare name; holds definitions only.
`ifndef ODAC_DEFS_SVH
`define ODAC_DEFS_SVH
`define ODAC_GLOBAL_ADDR 7'h73
`define ODAC_ADDR_BASE 7'h10
`define ODAC_BYTES_PER_WORD 2'd3
`define ODAC_CMD_MSB 23
`define ODAC_CMD_LSB 20
`define ODAC_CH_MSB 19
`define ODAC_CH_LSB 16
`define ODAC_DATA_MSB 15
`define ODAC_FILT_NS 50
`define ODAC_CLK_NS 8
`define ODAC_FILT_CYC ((`ODAC_FILT_NS + `ODAC_CLK_NS - 1) / `ODAC_CLK_NS)
`define ODAC_CODE_ZERO 16'h0000
`define ODAC_CODE_MID 16'h8000
`define ODAC_CMD_WRITE 4'h0
`define ODAC_CMD_UPDATE 4'h1
`define ODAC_CMD_WR_UPD_ALL 4'h2
`define ODAC_CMD_WR_UPD 4'h3
`define ODAC_CH_ALL 4'hF
`endif

// ===== logic/odac_pkg.sv
// Types of the octal DAC two-wire slave front end.
// Assumes odac_defs.svh for numeric constants.
package odac_pkg;
    typedef enum logic [1:0] {ODAC_POR_ZERO, ODAC_POR_MID_INT, ODAC_POR_MID_EXT} odac_por_t;
    typedef enum logic [1:0] {ODAC_PIN_GND, ODAC_PIN_FLOAT, ODAC_PIN_VCC} odac_pin_t;
endpackage

// ===== logic/odac_buf2.sv
// Two-entry buffer for completed 24-bit words.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module odac_buf2 (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [23:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [23:0] o_out_data
);
    logic [23:0] mem [2];
    logic wp, rp;
    logic [1:0] cnt;
    logic next_wp, next_rp;
    logic [1:0] next_cnt;
    logic push, pop;
    assign o_in_ready = (cnt != 2'd2);
    assign o_out_valid = (cnt != 2'd0);
    assign o_out_data = mem[rp];
    always_comb begin
        push = i_in_valid && o_in_ready;
        pop = o_out_valid && i_out_ready;
        next_wp = push ? ~wp : wp;
        next_rp = pop ? ~rp : rp;
        next_cnt = cnt + {1'b0, push} - {1'b0, pop};
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wp <= 1'b0;
            rp <= 1'b0;
            cnt <= 2'd0;
            mem[0] <= 24'h000000;
            mem[1] <= 24'h000000;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            if (push) begin
                mem[wp] <= i_in_data;
            end
        end
    end
endmodule

// ===== logic/odac_slave.sv
// What this block does
// R1: Data bit sampled at each rising serial clock edge.
// R2: Data line released while bits are received.
// R3: Acknowledge only pulls low, never drives high.
// R4: Write-only slave; reads get not-acknowledge.
// R5: Data falling with clock high starts a transaction.
// R6: Data rising with clock high ends it; bus free.
// R7: Master keeps both lines high when idle.
// R8: Zero-scale option loads code zero at power-up.
// R9: Mid-scale options load MSB-only code at power-up.
// R10: Internal-reference mid-scale option starts in internal reference mode.
// R11: External-reference mid-scale option starts in external reference mode.
// R12: Address from three-state select pins.
// R13: Output equals code over two to N times reference.
// R14: Resolution 12/10/8 and power-on option are parameters.
// R15: Acknowledge address only on match or global, write bit.
// R16: Ack three data bytes, execute word, refuse extra bytes.
// R17: Byte one is command and channel; then 16-bit left-justified code.
// R18: Read address gets data line high in ack slot.
// R19: Inputs synchronised and filtered before edge detection.
//
// Top of the two-wire slave front end; reset is the power-on reset.
// Assumes the lines pass external pull-ups; o_sda_oe high pulls low.
`timescale 1ns/1ps
`include "odac_defs.svh"
module odac_slave #(
    parameter int RES = 12,
    parameter odac_pkg::odac_por_t POR = odac_pkg::ODAC_POR_ZERO
) (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    input wire odac_pkg::odac_pin_t i_address_select_0,
    input wire odac_pkg::odac_pin_t i_address_select_1,
    input wire odac_pkg::odac_pin_t i_address_select_2,
    output logic [127:0] o_dac_code,
    output logic o_int_ref,
    output logic [7:0] o_word_cnt
);
    // ==========================================
    // Input synchronisers and glitch filter
    localparam int FILT = `ODAC_FILT_CYC;
    logic [2:0] scl_sync, sda_sync;
    logic scl_f, sda_f, scl_d, sda_d;
    logic [3:0] scl_cnt, sda_cnt;
    logic next_scl_f, next_sda_f;
    logic [3:0] next_scl_cnt, next_sda_cnt;
    // Stable only after second and third stage agree for FILT cycles
    always_comb begin
        next_scl_f = scl_f;
        next_sda_f = sda_f;
        next_scl_cnt = 4'd0;
        next_sda_cnt = 4'd0;
        if (scl_sync[2] == scl_sync[1] && scl_sync[2] != scl_f) begin
            next_scl_cnt = scl_cnt + 4'd1;
            if (scl_cnt == 4'(FILT - 1)) begin
                next_scl_f = scl_sync[2]; // R19
            end
        end
        if (sda_sync[2] == sda_sync[1] && sda_sync[2] != sda_f) begin
            next_sda_cnt = sda_cnt + 4'd1;
            if (sda_cnt == 4'(FILT - 1)) begin
                next_sda_f = sda_sync[2]; // R19
            end
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            scl_sync <= 3'b111;
            sda_sync <= 3'b111;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            scl_cnt <= 4'd0;
            sda_cnt <= 4'd0;
        end else begin
            scl_sync <= {scl_sync[1:0], i_scl};
            sda_sync <= {sda_sync[1:0], i_sda};
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
            scl_d <= scl_f;
            sda_d <= sda_f;
            scl_cnt <= next_scl_cnt;
            sda_cnt <= next_sda_cnt;
        end
    end
    logic scl_rise, scl_fall, start_c, stop_c;
    assign scl_rise = scl_f && !scl_d;
    assign scl_fall = !scl_f && scl_d;
    assign start_c = scl_f && scl_d && sda_d && !sda_f; // R5
    assign stop_c = scl_f && scl_d && !sda_d && sda_f; // R6

    // ==========================================
    // Slave address from three-state pins
    function automatic logic [1:0] pin_val(input odac_pkg::odac_pin_t p);
        case (p)
            odac_pkg::ODAC_PIN_GND: pin_val = 2'd0;
            odac_pkg::ODAC_PIN_FLOAT: pin_val = 2'd1;
            default: pin_val = 2'd2;
        endcase
    endfunction
    logic [4:0] sel_idx;
    logic [6:0] own_addr;
    // Table packs four addresses per 16-block: idx -> base + (idx/4)*16 + idx%4
    assign sel_idx = 5'(pin_val(i_address_select_2) * 9 + pin_val(i_address_select_1) * 3
        + pin_val(i_address_select_0));
    assign own_addr = `ODAC_ADDR_BASE + {sel_idx[4:2], 4'h0} + {5'd0, sel_idx[1:0]}; // R12

    // ==========================================
    // Byte receiver
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_ACK, ST_IGNORE} odac_st_t;
    odac_st_t st, next_st;
    logic [7:0] shreg, next_shreg;
    logic [3:0] bitn, next_bitn;
    logic [1:0] nbytes, next_nbytes;
    logic [23:0] word, next_word;
    logic ack, next_ack, in_addr, next_in_addr, wvalid, next_wvalid;
    logic buf_ready;
    always_comb begin
        next_st = st;
        next_shreg = shreg;
        next_bitn = bitn;
        next_nbytes = nbytes;
        next_word = word;
        next_ack = ack;
        next_in_addr = in_addr;
        next_wvalid = wvalid && !buf_ready;
        case (st)
            ST_IDLE: begin
                next_ack = 1'b0;
            end
            ST_ADDR, ST_DATA: begin
                if (scl_rise) begin
                    next_shreg = {shreg[6:0], sda_f}; // R1
                    next_bitn = bitn + 4'd1;
                end
                if (scl_fall && bitn == 4'd8) begin
                    next_st = ST_ACK;
                    next_bitn = 4'd0;
                    if (st == ST_ADDR) begin
                        // Read bit set: leave line high
                        next_ack = !shreg[0] && (shreg[7:1] == own_addr
                            || shreg[7:1] == `ODAC_GLOBAL_ADDR); // R15 R4 R18
                        next_nbytes = 2'd0;
                    end else begin
                        // Third byte refused if a word is pending or buffer full; refused bytes not acked
                        next_ack = nbytes != `ODAC_BYTES_PER_WORD
                            && !(nbytes == 2'd2 && (wvalid || !buf_ready)); // R16
                        if (next_ack) begin
                            next_word = {word[15:0], shreg}; // R17
                            next_nbytes = nbytes + 2'd1;
                            next_wvalid = wvalid || nbytes == 2'd2;
                        end
                    end
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    next_st = ack ? ST_DATA : ST_IGNORE;
                    next_ack = 1'b0;
                end
            end
            ST_IGNORE: begin
                next_ack = 1'b0;
            end
            default: begin
                next_st = ST_IDLE;
            end
        endcase
        if (start_c) begin
            next_st = ST_ADDR;
            next_bitn = 4'd0;
            next_ack = 1'b0;
        end else if (stop_c) begin
            next_st = ST_IDLE; // R6
            next_ack = 1'b0;
        end
        next_in_addr = next_st == ST_ADDR;
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= ST_IDLE;
            shreg <= 8'h00;
            bitn <= 4'd0;
            nbytes <= 2'd0;
            word <= 24'h000000;
            ack <= 1'b0;
            in_addr <= 1'b0;
            wvalid <= 1'b0;
        end else begin
            st <= next_st;
            shreg <= next_shreg;
            bitn <= next_bitn;
            nbytes <= next_nbytes;
            word <= next_word;
            ack <= next_ack;
            in_addr <= next_in_addr;
            wvalid <= next_wvalid;
        end
    end
    // Open-drain: output level fixed low, only enable moves
    assign o_sda = 1'b0; // R3
    assign o_sda_oe = (st == ST_ACK) && ack; // R2 R3

    // ==========================================
    // Word buffer and execution
    logic bo_valid;
    logic [23:0] bo_data;
    odac_buf2 u_buf (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_in_valid(wvalid),
        .o_in_ready(buf_ready),
        .i_in_data(word),
        .o_out_valid(bo_valid),
        .i_out_ready(1'b1),
        .o_out_data(bo_data)
    );
    localparam logic [15:0] POR_CODE = (POR == odac_pkg::ODAC_POR_ZERO) ?
        `ODAC_CODE_ZERO : `ODAC_CODE_MID; // R8 R9
    logic [15:0] inreg [8];
    logic [15:0] dacreg [8];
    logic [15:0] mask;
    logic [7:0] wcnt;
    assign mask = 16'hFFFF << (16 - RES); // R14 R17
    // Output code k scaled by ref/2^N off-chip; code left-justified
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            o_dac_code[i*16 +: 16] = dacreg[i]; // R13
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            for (int i = 0; i < 8; i++) begin
                inreg[i] <= POR_CODE;
                dacreg[i] <= POR_CODE;
            end
            o_int_ref <= (POR != odac_pkg::ODAC_POR_MID_EXT); // R10 R11
            wcnt <= 8'h00;
        end else if (bo_valid) begin
            wcnt <= wcnt + 8'h01;
            for (int i = 0; i < 8; i++) begin
                if (bo_data[`ODAC_CH_MSB:`ODAC_CH_LSB] == 4'(i)
                    || bo_data[`ODAC_CH_MSB:`ODAC_CH_LSB] == `ODAC_CH_ALL) begin
                    case (bo_data[`ODAC_CMD_MSB:`ODAC_CMD_LSB])
                        `ODAC_CMD_WRITE: inreg[i] <= bo_data[15:0] & mask;
                        `ODAC_CMD_UPDATE: dacreg[i] <= inreg[i];
                        `ODAC_CMD_WR_UPD, `ODAC_CMD_WR_UPD_ALL: begin
                            inreg[i] <= bo_data[15:0] & mask;
                            dacreg[i] <= bo_data[15:0] & mask;
                        end
                        default: begin
                        end
                    endcase
                end
                if (bo_data[`ODAC_CMD_MSB:`ODAC_CMD_LSB] == `ODAC_CMD_WR_UPD_ALL
                    && bo_data[`ODAC_CH_MSB:`ODAC_CH_LSB] != `ODAC_CH_ALL) begin
                    dacreg[i] <= (bo_data[`ODAC_CH_MSB:`ODAC_CH_LSB] == 4'(i)) ?
                        (bo_data[15:0] & mask) : inreg[i];
                end
            end
        end
    end
    assign o_word_cnt = wcnt; // R16

    // ==========================================
    // Checks
    sequence s_start;
        start_c;
    endsequence
    property p_start_addr;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
            s_start |=> in_addr && st == ST_ADDR && bitn == 4'd0 && !o_sda_oe;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not seen"); // R5
    property p_stop_idle;
        @(posedge i_ref_clk) disable iff (!i_arst_n) stop_c |=> st == ST_IDLE;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop not seen"); // R6
    property p_release;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
            (st == ST_ADDR || st == ST_DATA) |-> !o_sda_oe;
    endproperty
    a_release: assert property (p_release) else $error("sda driven in bits"); // R2
    property p_od;
        @(posedge i_ref_clk) disable iff (!i_arst_n) o_sda_oe |-> o_sda == 1'b0;
    endproperty
    a_od: assert property (p_od) else $error("sda driven high"); // R3
    property p_read_nak;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
            (st == ST_ADDR && scl_fall && bitn == 4'd8 && shreg[0] && !start_c && !stop_c)
            |=> !o_sda_oe;
    endproperty
    a_read_nak: assert property (p_read_nak) else $error("read acked"); // R4
    property p_sample;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
            (st == ST_DATA && scl_rise && !start_c && !stop_c) |=> shreg[0] == $past(sda_f);
    endproperty
    a_sample: assert property (p_sample) else $error("bit not sampled"); // R1
    property p_exec;
        @(posedge i_ref_clk) disable iff (!i_arst_n) bo_valid |=> wcnt == $past(wcnt) + 8'h01;
    endproperty
    a_exec: assert property (p_exec) else $error("word not executed"); // R16
    property p_extra;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
            (st == ST_DATA && scl_fall && bitn == 4'd8 && nbytes == 2'd3
            && !start_c && !stop_c) |=> !ack;
    endproperty
    a_extra: assert property (p_extra) else $error("extra byte acked"); // R16
endmodule

// ===== sim/odac_master.sv
// Two-wire bus master model driving the serial clock and data lines.
// Assumes a pulled-up data line fed back on i_sda; o_sda_low pulls it.
`timescale 1ns/1ps
module odac_master (
    input wire logic i_ref_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    // ========================================
    // Line control
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask

    // Low phase of 16 cycles: the slave releases its ack about 10 cycles late
    task automatic bit_io(input logic b, output logic r);
        o_sda_low <= ~b;
        tick(8);
        o_scl <= 1'b1;
        tick(9);
        @(negedge i_ref_clk);
        r = i_sda;
        @(posedge i_ref_clk);
        o_scl <= 1'b0;
        tick(8);
    endtask

    // Also serves as repeated start
    task automatic start();
        o_sda_low <= 1'b0;
        tick(16);
        o_scl <= 1'b1;
        tick(10);
        o_sda_low <= 1'b1;
        tick(10);
        o_scl <= 1'b0;
        tick(8);
    endtask

    task automatic stop();
        o_sda_low <= 1'b1;
        tick(8);
        o_scl <= 1'b1;
        tick(10);
        o_sda_low <= 1'b0;
        tick(16);
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack, output logic clash);
        logic r;
        clash = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
            if (r !== d[i]) clash = 1'b1;
        end
        bit_io(1'b1, r);
        ack = (r === 1'b0);
    endtask
endmodule

// ===== sim/tb_odac_slave.sv
// Self-checking bench: three slaves with different options on one bus.
// Assumes odac_defs.svh on the include path and the master model.
`timescale 1ns/1ps
`include "odac_defs.svh"
module tb_odac_slave;
    logic clk, arst_n, scl, sda_low;
    odac_pkg::odac_pin_t sel0, sel1, sel2, hi, xs0, xs1, xs2;
    logic [127:0] code_z, code_mi, code_mx;
    logic ref_z, ref_mi, ref_mx, oe_z, oe_mi, oe_mx, so_z, so_mi, so_mx;
    logic [7:0] cnt_z, cnt_mi, cnt_mx, cnt0;
    // Open drain: a slave pulls only while enabled and its level is low
    wire logic sda = ~(sda_low | (oe_z & ~so_z) | (oe_mi & ~so_mi) | (oe_mx & ~so_mx));
    int errors, compares;

    // ========================================
    // Clock, reset, instances
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    odac_master m (.i_ref_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
    odac_slave #(.RES(12), .POR(odac_pkg::ODAC_POR_ZERO)) uut (.i_ref_clk(clk),
        .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda), .o_sda(so_z), .o_sda_oe(oe_z),
        .i_address_select_0(sel0), .i_address_select_1(sel1), .i_address_select_2(sel2),
        .o_dac_code(code_z), .o_int_ref(ref_z), .o_word_cnt(cnt_z));
    odac_slave #(.RES(10), .POR(odac_pkg::ODAC_POR_MID_INT)) u_mid_int (.i_ref_clk(clk),
        .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda), .o_sda(so_mi), .o_sda_oe(oe_mi),
        .i_address_select_0(hi), .i_address_select_1(hi), .i_address_select_2(hi),
        .o_dac_code(code_mi), .o_int_ref(ref_mi), .o_word_cnt(cnt_mi));
    odac_slave #(.RES(8), .POR(odac_pkg::ODAC_POR_MID_EXT)) u_mid_ext (.i_ref_clk(clk),
        .i_arst_n(arst_n), .i_scl(scl), .i_sda(sda), .o_sda(so_mx), .o_sda_oe(oe_mx),
        .i_address_select_0(xs0), .i_address_select_1(xs1), .i_address_select_2(xs2),
        .o_dac_code(code_mx), .o_int_ref(ref_mx), .o_word_cnt(cnt_mx));

    // ========================================
    // Helpers
    function automatic logic [6:0] addr_of(input int idx);
        return `ODAC_ADDR_BASE + 7'((idx / 4) * 16 + idx % 4);
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic [6:0] a, input logic rw, input logic [31:0] w,
                        input int nb, input logic [4:0] ea, input logic stp);
        logic ak, cl;
        m.start();
        m.wbyte({a, rw}, ak, cl);
        chk("addr_ack", ak, ea[4]);
        chk("addr_released", cl, 1'b0);
        for (int i = 0; i < nb; i++) begin
            m.wbyte(w[31-8*i -: 8], ak, cl);
            chk("data_ack", ak, ea[3-i]);
            chk("data_released", cl, 1'b0);
        end
        if (stp) m.stop();
    endtask

    // ========================================
    // Scenarios
    task automatic t_por();
        for (int k = 0; k < 8; k++) begin
            chk("code_zero", code_z[16*k +: 16], `ODAC_CODE_ZERO);
            chk("code_mid_int", code_mi[16*k +: 16], `ODAC_CODE_MID);
            chk("code_mid_ext", code_mx[16*k +: 16], `ODAC_CODE_MID);
        end
        chk("ref_mid_int", ref_mi, 1'b1);
        chk("ref_mid_ext", ref_mx, 1'b0);
        chk("ref_zero", ref_z, 1'b1);
        chk("cnt_por", {cnt_z, cnt_mi, cnt_mx}, 24'h000000);
        chk("drain_level", {so_z, so_mi, so_mx}, 3'b000);
        $display("test por done");
    endtask

    task automatic t_addr();
        int j;
        for (int idx = 0; idx < 27; idx++) begin
            // Third slave swept too, never on the same address as the others
            j = (idx + 13) % 26;
            sel0 <= odac_pkg::odac_pin_t'(idx % 3);
            sel1 <= odac_pkg::odac_pin_t'((idx / 3) % 3);
            sel2 <= odac_pkg::odac_pin_t'(idx / 9);
            xs0 <= odac_pkg::odac_pin_t'(j % 3);
            xs1 <= odac_pkg::odac_pin_t'((j / 3) % 3);
            xs2 <= odac_pkg::odac_pin_t'(j / 9);
            m.tick(4);
            xfer(addr_of(idx), 1'b0, 32'h0, 0, 5'b10000, 1'b1);
            xfer(addr_of(j), 1'b0, 32'h0, 0, 5'b10000, 1'b1);
        end
        xs0 <= odac_pkg::ODAC_PIN_FLOAT;
        xs1 <= odac_pkg::ODAC_PIN_VCC;
        xs2 <= odac_pkg::ODAC_PIN_VCC;
        sel0 <= odac_pkg::ODAC_PIN_GND;
        sel1 <= odac_pkg::ODAC_PIN_GND;
        sel2 <= odac_pkg::ODAC_PIN_GND;
        m.tick(4);
        xfer(7'h0F, 1'b0, 32'h0, 0, 5'b00000, 1'b1);
        xfer(addr_of(0), 1'b1, 32'hFF00_0000, 1, 5'b00000, 1'b1);
        $display("test addr done");
    endtask

    task automatic t_write();
        cnt0 = cnt_z;
        xfer(addr_of(0), 1'b0, 32'h32AB_CD55, 4, 5'b11110, 1'b1);
        chk("code_ch2", code_z[47:32], 16'hABC0);
        chk("word_cnt", cnt_z, cnt0 + 8'h01);
        chk("other_ch2", code_mi[47:32], `ODAC_CODE_MID);
        $display("test write done");
    endtask

    task automatic t_cmds();
        xfer(addr_of(0), 1'b0, 32'h055A_5000, 3, 5'b11110, 1'b1);
        chk("held_ch5", code_z[95:80], 16'h0000);
        xfer(addr_of(0), 1'b0, 32'h1500_0000, 3, 5'b11110, 1'b1);
        chk("upd_ch5", code_z[95:80], 16'h5A50);
        xfer(addr_of(0), 1'b0, 32'h3F0F_F000, 3, 5'b11110, 1'b1);
        xfer(`ODAC_GLOBAL_ADDR, 1'b0, 32'h2F12_F400, 3, 5'b11110, 1'b1);
        for (int k = 0; k < 8; k++) begin
            chk("all_z", code_z[16*k +: 16], 16'h12F0);
            chk("all_mi", code_mi[16*k +: 16], 16'h12C0);
            chk("all_mx", code_mx[16*k +: 16], 16'h1200);
        end
        chk("cnt_mi", cnt_mi, 8'h01);
        chk("cnt_mx", cnt_mx, 8'h01);
        // Write one channel, then write another and update all
        xfer(addr_of(0), 1'b0, 32'h0144_4000, 3, 5'b11110, 1'b1);
        xfer(addr_of(0), 1'b0, 32'h2377_7000, 3, 5'b11110, 1'b1);
        chk("wua_ch1", code_z[31:16], 16'h4440);
        chk("wua_ch3", code_z[63:48], 16'h7770);
        chk("wua_ch0", code_z[15:0], 16'h12F0);
        $display("test cmds done");
    endtask

    task automatic t_abort();
        cnt0 = cnt_z;
        xfer(addr_of(0), 1'b0, 32'h30FF_FF00, 2, 5'b11100, 1'b1);
        xfer(addr_of(0), 1'b0, 32'h30EE_EE00, 2, 5'b11100, 1'b0);
        xfer(addr_of(0), 1'b0, 32'h303C_3F00, 3, 5'b11110, 1'b1);
        chk("code_ch0", code_z[15:0], 16'h3C30);
        chk("abort_cnt", cnt_z, cnt0 + 8'h01);
        $display("test abort done");
    endtask

    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ========================================
    // Main sequence and watchdog
    initial begin
        errors = 0;
        compares = 0;
        arst_n = 1'b0;
        hi = odac_pkg::ODAC_PIN_VCC;
        xs0 = odac_pkg::ODAC_PIN_FLOAT;
        xs1 = odac_pkg::ODAC_PIN_VCC;
        xs2 = odac_pkg::ODAC_PIN_VCC;
        sel0 = odac_pkg::ODAC_PIN_GND;
        sel1 = odac_pkg::ODAC_PIN_GND;
        sel2 = odac_pkg::ODAC_PIN_GND;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        m.tick(4);
        t_por();
        t_addr();
        t_write();
        t_cmds();
        t_abort();
        // Second reset mid-run must restore the power-on codes
        arst_n <= 1'b0;
        m.tick(2);
        arst_n <= 1'b1;
        m.tick(4);
        t_por();
        give_verdict();
    end

    initial begin
        // Run needs about 30k cycles; limit near 50k cycles
        #400_000;
        errors++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule
